// ==== rtl/low_speed_periph_reset.sv ====
`timescale 1ns/100ps
`default_nettype none
module low_speed_periph_reset
  import periph_reset_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire apb_req_type apb_req,
  output var apb_rsp_type apb_rsp,
  output logic [31:0] periph_reset
);
  logic [31:0] low_speed_bus_peripheral_reset_reg;
  logic [31:0] low_speed_bus_peripheral_reset_next;
  logic [31:0] merged_word;
  apb_rsp_type rsp_reg;
  apb_rsp_type rsp_next;
  logic hit;
  logic wr_fire;

  assign hit = (apb_req.paddr[11:2] == LOW_SPEED_BUS_PERIPHERAL_RESET_OFFSET[11:2]);
  // Zero-wait slave: access phase completes on its first edge
  assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite && hit;

  // Byte lanes let half-word and byte writes touch only their bits
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : lanes
      byte_lane_merge merge_u (
        .old_byte(low_speed_bus_peripheral_reset_reg[lane*8 +: 8]),
        .new_byte(apb_req.pwdata[lane*8 +: 8]),
        .keep_mask(WRITABLE_MASK[lane*8 +: 8]),
        .lane_en(apb_req.pstrb[lane]),
        .merged(merged_word[lane*8 +: 8])
      );
    end
  endgenerate

  always_comb begin
    low_speed_bus_peripheral_reset_next = low_speed_bus_peripheral_reset_reg;
    if (wr_fire) begin
      low_speed_bus_peripheral_reset_next = merged_word;
    end
  end

  always_comb begin
    rsp_next.pready = apb_req.psel && !apb_req.penable;
    rsp_next.pslverr = apb_req.psel && !apb_req.penable && !hit;
    rsp_next.prdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit) begin
      // Write-through read sees stored value; reserved bits never stored
      rsp_next.prdata = low_speed_bus_peripheral_reset_reg & WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_speed_bus_peripheral_reset_reg <= LOW_SPEED_BUS_PERIPHERAL_RESET_RESET;
      rsp_reg <= '0;
    end else begin
      low_speed_bus_peripheral_reset_reg <= low_speed_bus_peripheral_reset_next;
      rsp_reg <= rsp_next;
    end
  end

  // Outputs are the register itself, so a peripheral sees its reset one edge after the write
  assign periph_reset = low_speed_bus_peripheral_reset_reg;
  assign apb_rsp = rsp_reg;

  // Named views of each reset line, used by the checks below
  logic power_if_reset_bit;
  logic backup_if_reset_bit;
  logic third_i2c_reset_bit;
  logic can_ctrl_reset_bit;
  logic usb_ctrl_reset_bit;
  logic second_i2c_reset_bit;
  logic first_i2c_reset_bit;
  logic uart_five_reset_bit;
  logic uart_four_reset_bit;
  logic usart_three_reset_bit;
  logic usart_two_reset_bit;
  logic spi_four_reset_bit;
  logic spi_three_reset_bit;
  logic spi_two_reset_bit;
  logic window_watchdog_reset_bit;
  logic timer_fourteen_reset_bit;
  logic timer_thirteen_reset_bit;
  logic timer_twelve_reset_bit;
  logic timer_seven_reset_bit;
  logic timer_six_reset_bit;
  logic timer_five_reset_bit;
  logic timer_four_reset_bit;
  logic timer_three_reset_bit;
  logic timer_two_reset_bit;

  assign power_if_reset_bit = low_speed_bus_peripheral_reset_reg[POWER_IF_BIT];
  assign backup_if_reset_bit = low_speed_bus_peripheral_reset_reg[BACKUP_IF_BIT];
  // Bit 26 goes to the third I2C controller, not a second CAN one; its target is uncertain
  assign third_i2c_reset_bit = low_speed_bus_peripheral_reset_reg[THIRD_I2C_BIT];
  assign can_ctrl_reset_bit = low_speed_bus_peripheral_reset_reg[CAN_CTRL_BIT];
  assign usb_ctrl_reset_bit = low_speed_bus_peripheral_reset_reg[USB_CTRL_BIT];
  assign second_i2c_reset_bit = low_speed_bus_peripheral_reset_reg[SECOND_I2C_BIT];
  assign first_i2c_reset_bit = low_speed_bus_peripheral_reset_reg[FIRST_I2C_BIT];
  assign uart_five_reset_bit = low_speed_bus_peripheral_reset_reg[UART_FIVE_BIT];
  assign uart_four_reset_bit = low_speed_bus_peripheral_reset_reg[UART_FOUR_BIT];
  assign usart_three_reset_bit = low_speed_bus_peripheral_reset_reg[USART_THREE_BIT];
  assign usart_two_reset_bit = low_speed_bus_peripheral_reset_reg[USART_TWO_BIT];
  assign spi_four_reset_bit = low_speed_bus_peripheral_reset_reg[SPI_FOUR_BIT];
  assign spi_three_reset_bit = low_speed_bus_peripheral_reset_reg[SPI_THREE_BIT];
  assign spi_two_reset_bit = low_speed_bus_peripheral_reset_reg[SPI_TWO_BIT];
  assign window_watchdog_reset_bit = low_speed_bus_peripheral_reset_reg[WINDOW_WATCHDOG_BIT];
  assign timer_fourteen_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_FOURTEEN_BIT];
  assign timer_thirteen_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_THIRTEEN_BIT];
  assign timer_twelve_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_TWELVE_BIT];
  assign timer_seven_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_SEVEN_BIT];
  assign timer_six_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_SIX_BIT];
  assign timer_five_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_FIVE_BIT];
  assign timer_four_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_FOUR_BIT];
  assign timer_three_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_THREE_BIT];
  assign timer_two_reset_bit = low_speed_bus_peripheral_reset_reg[TIMER_TWO_BIT];

  power_backup_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[3]) |-> periph_reset[POWER_IF_BIT] == $past(apb_req.pwdata[POWER_IF_BIT])
      && periph_reset[BACKUP_IF_BIT] == $past(apb_req.pwdata[BACKUP_IF_BIT]))
    else $error("power or backup reset bit not written");
  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (periph_reset & ~WRITABLE_MASK) == 32'h0000_0000)
    else $error("reserved reset bit set");
  hold_value_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(wr_fire) |-> $stable(periph_reset))
    else $error("reset bits changed without write");
  lane_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && !$past(apb_req.pstrb[0]) |-> periph_reset[7:0] == $past(periph_reset[7:0]))
    else $error("unstrobed lane changed");
  zero_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("access phase not ready at once");
  timer_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      periph_reset[TIMER_FOURTEEN_BIT - 1:TIMER_TWO_BIT] == $past(apb_req.pwdata[7:0]))
    else $error("timer reset bits wrong");
  read_back_a: assert property (@(posedge clk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit ##1 apb_req.penable |->
      apb_rsp.prdata == periph_reset)
    else $error("read data differs from reset bits");
  serial_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      periph_reset[UART_FIVE_BIT:USART_TWO_BIT] == $past(apb_req.pwdata[20:17]))
    else $error("serial reset bits wrong");

  // Each named line follows its own byte lane on a write
  power_if_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[3]) |->
      power_if_reset_bit == $past(apb_req.pwdata[POWER_IF_BIT]))
    else $error("power interface reset not written");
  backup_if_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[3]) |->
      backup_if_reset_bit == $past(apb_req.pwdata[BACKUP_IF_BIT]))
    else $error("backup interface reset not written");
  third_i2c_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[3]) |->
      third_i2c_reset_bit == $past(apb_req.pwdata[THIRD_I2C_BIT]))
    else $error("third I2C reset not written");
  can_ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[3]) |->
      can_ctrl_reset_bit == $past(apb_req.pwdata[CAN_CTRL_BIT]))
    else $error("CAN reset not written");
  usb_ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      usb_ctrl_reset_bit == $past(apb_req.pwdata[USB_CTRL_BIT]))
    else $error("USB reset not written");
  second_i2c_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      second_i2c_reset_bit == $past(apb_req.pwdata[SECOND_I2C_BIT]))
    else $error("second I2C reset not written");
  first_i2c_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      first_i2c_reset_bit == $past(apb_req.pwdata[FIRST_I2C_BIT]))
    else $error("first I2C reset not written");
  uart_five_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      uart_five_reset_bit == $past(apb_req.pwdata[UART_FIVE_BIT]))
    else $error("UART five reset not written");
  uart_four_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      uart_four_reset_bit == $past(apb_req.pwdata[UART_FOUR_BIT]))
    else $error("UART four reset not written");
  usart_three_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      usart_three_reset_bit == $past(apb_req.pwdata[USART_THREE_BIT]))
    else $error("USART three reset not written");
  usart_two_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      usart_two_reset_bit == $past(apb_req.pwdata[USART_TWO_BIT]))
    else $error("USART two reset not written");
  spi_four_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[2]) |->
      spi_four_reset_bit == $past(apb_req.pwdata[SPI_FOUR_BIT]))
    else $error("SPI four reset not written");
  spi_three_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[1]) |->
      spi_three_reset_bit == $past(apb_req.pwdata[SPI_THREE_BIT]))
    else $error("SPI three reset not written");
  spi_two_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[1]) |->
      spi_two_reset_bit == $past(apb_req.pwdata[SPI_TWO_BIT]))
    else $error("SPI two reset not written");
  window_watchdog_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[1]) |->
      window_watchdog_reset_bit == $past(apb_req.pwdata[WINDOW_WATCHDOG_BIT]))
    else $error("watchdog reset not written");
  timer_fourteen_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[1]) |->
      timer_fourteen_reset_bit == $past(apb_req.pwdata[TIMER_FOURTEEN_BIT]))
    else $error("timer fourteen reset not written");
  timer_thirteen_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_thirteen_reset_bit == $past(apb_req.pwdata[TIMER_THIRTEEN_BIT]))
    else $error("timer thirteen reset not written");
  timer_twelve_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_twelve_reset_bit == $past(apb_req.pwdata[TIMER_TWELVE_BIT]))
    else $error("timer twelve reset not written");
  timer_seven_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_seven_reset_bit == $past(apb_req.pwdata[TIMER_SEVEN_BIT]))
    else $error("timer seven reset not written");
  timer_six_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_six_reset_bit == $past(apb_req.pwdata[TIMER_SIX_BIT]))
    else $error("timer six reset not written");
  timer_five_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_five_reset_bit == $past(apb_req.pwdata[TIMER_FIVE_BIT]))
    else $error("timer five reset not written");
  timer_four_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_four_reset_bit == $past(apb_req.pwdata[TIMER_FOUR_BIT]))
    else $error("timer four reset not written");
  timer_three_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_three_reset_bit == $past(apb_req.pwdata[TIMER_THREE_BIT]))
    else $error("timer three reset not written");
  timer_two_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(wr_fire) && $past(apb_req.pstrb[0]) |->
      timer_two_reset_bit == $past(apb_req.pwdata[TIMER_TWO_BIT]))
    else $error("timer two reset not written");

  // Lanes that were not strobed must leave their lines alone
  power_if_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[3])) |-> $stable(power_if_reset_bit))
    else $error("power interface reset changed unasked");
  backup_if_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[3])) |-> $stable(backup_if_reset_bit))
    else $error("backup interface reset changed unasked");
  third_i2c_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[3])) |-> $stable(third_i2c_reset_bit))
    else $error("third I2C reset changed unasked");
  can_ctrl_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[3])) |-> $stable(can_ctrl_reset_bit))
    else $error("CAN reset changed unasked");
  usb_ctrl_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(usb_ctrl_reset_bit))
    else $error("USB reset changed unasked");
  second_i2c_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(second_i2c_reset_bit))
    else $error("second I2C reset changed unasked");
  first_i2c_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(first_i2c_reset_bit))
    else $error("first I2C reset changed unasked");
  uart_five_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(uart_five_reset_bit))
    else $error("UART five reset changed unasked");
  uart_four_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(uart_four_reset_bit))
    else $error("UART four reset changed unasked");
  usart_three_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(usart_three_reset_bit))
    else $error("USART three reset changed unasked");
  usart_two_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(usart_two_reset_bit))
    else $error("USART two reset changed unasked");
  spi_four_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[2])) |-> $stable(spi_four_reset_bit))
    else $error("SPI four reset changed unasked");
  spi_three_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[1])) |-> $stable(spi_three_reset_bit))
    else $error("SPI three reset changed unasked");
  spi_two_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[1])) |-> $stable(spi_two_reset_bit))
    else $error("SPI two reset changed unasked");
  window_watchdog_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[1])) |-> $stable(window_watchdog_reset_bit))
    else $error("watchdog reset changed unasked");
  timer_fourteen_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[1])) |-> $stable(timer_fourteen_reset_bit))
    else $error("timer fourteen reset changed unasked");
  timer_thirteen_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_thirteen_reset_bit))
    else $error("timer thirteen reset changed unasked");
  timer_twelve_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_twelve_reset_bit))
    else $error("timer twelve reset changed unasked");
  timer_seven_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_seven_reset_bit))
    else $error("timer seven reset changed unasked");
  timer_six_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_six_reset_bit))
    else $error("timer six reset changed unasked");
  timer_five_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_five_reset_bit))
    else $error("timer five reset changed unasked");
  timer_four_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_four_reset_bit))
    else $error("timer four reset changed unasked");
  timer_three_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_three_reset_bit))
    else $error("timer three reset changed unasked");
  timer_two_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !($past(wr_fire) && $past(apb_req.pstrb[0])) |-> $stable(timer_two_reset_bit))
    else $error("timer two reset changed unasked");
endmodule
`default_nettype wire

// ==== rtl/periph_reset_pkg.sv ====
package periph_reset_pkg;
  localparam logic [11:0] LOW_SPEED_BUS_PERIPHERAL_RESET_OFFSET = 12'h010;
  localparam logic [31:0] LOW_SPEED_BUS_PERIPHERAL_RESET_RESET = 32'h0000_0000;
  localparam logic [31:0] WRITABLE_MASK = 32'h1ef_fc9ff;
  localparam int TIMER_TWO_BIT = 0;
  localparam int TIMER_THREE_BIT = 1;
  localparam int TIMER_FOUR_BIT = 2;
  localparam int TIMER_FIVE_BIT = 3;
  localparam int TIMER_SIX_BIT = 4;
  localparam int TIMER_SEVEN_BIT = 5;
  localparam int TIMER_TWELVE_BIT = 6;
  localparam int TIMER_THIRTEEN_BIT = 7;
  localparam int TIMER_FOURTEEN_BIT = 8;
  localparam int WINDOW_WATCHDOG_BIT = 11;
  localparam int SPI_TWO_BIT = 14;
  localparam int SPI_THREE_BIT = 15;
  localparam int SPI_FOUR_BIT = 16;
  localparam int USART_TWO_BIT = 17;
  localparam int USART_THREE_BIT = 18;
  localparam int UART_FOUR_BIT = 19;
  localparam int UART_FIVE_BIT = 20;
  localparam int FIRST_I2C_BIT = 21;
  localparam int SECOND_I2C_BIT = 22;
  localparam int USB_CTRL_BIT = 23;
  localparam int CAN_CTRL_BIT = 25;
  localparam int THIRD_I2C_BIT = 26;
  localparam int BACKUP_IF_BIT = 27;
  localparam int POWER_IF_BIT = 28;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
endpackage

// ==== rtl/byte_lane_merge.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_lane_merge (
  input wire logic [7:0] old_byte,
  input wire logic [7:0] new_byte,
  input wire logic [7:0] keep_mask,
  input wire logic lane_en,
  output logic [7:0] merged
);
  always_comb begin
    if (lane_en) begin
      merged = new_byte & keep_mask;
    end else begin
      merged = old_byte;
    end
  end
endmodule
`default_nettype wire

// ==== sim/periph_far_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module periph_far_end (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] periph_reset,
  output logic [31:0] seen
);
  // Peripherals only sample their reset line; any held bit is latched for the bench
  // System reset clears the record so lines unknown before the first edge never stick
  always @(posedge clk) begin
    if (sys_rst) begin
      seen <= '0;
    end else begin
      seen <= seen | periph_reset;
    end
  end
endmodule
`default_nettype wire

// ==== sim/low_speed_periph_reset_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module low_speed_periph_reset_test;
  import periph_reset_pkg::*;
  localparam logic [11:0] REG_ADDR = LOW_SPEED_BUS_PERIPHERAL_RESET_OFFSET;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic [31:0] prst;
  logic [31:0] seen;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int compares = 0;
  always #50 clk = ~clk;
  low_speed_periph_reset u_low_speed_periph_reset (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .periph_reset(prst));
  periph_far_end u_periph_far_end (.clk(clk), .sys_rst(sys_rst), .periph_reset(prst), .seen(seen));
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (n == 20) begin
      fail_count++;
      test_done();
    end
    chk(32'(n), 32'h0);
    @(posedge clk);
  endtask
  task t_reset;
    chk(prst, LOW_SPEED_BUS_PERIPHERAL_RESET_RESET);
    apb(1'b0, REG_ADDR, 32'h0, 4'h0);
    chk(rd, LOW_SPEED_BUS_PERIPHERAL_RESET_RESET);
    chk(seen, 32'h0);
    $display("done reset values");
  endtask
  task t_all;
    apb(1'b1, REG_ADDR, 32'hffff_ffff, 4'hf);
    chk(prst, WRITABLE_MASK);
    apb(1'b0, REG_ADDR, 32'h0, 4'h0);
    chk(rd, WRITABLE_MASK);
    chk(seen, WRITABLE_MASK);
    $display("done set all");
  endtask
  task t_lanes;
    apb(1'b1, REG_ADDR, 32'h0, 4'h2);
    chk(prst, WRITABLE_MASK & 32'hffff_00ff);
    apb(1'b1, REG_ADDR, 32'h0, 4'hc);
    chk(prst, WRITABLE_MASK & 32'h0000_00ff);
    apb(1'b1, REG_ADDR, 32'h0, 4'hf);
    chk(prst, 32'h0);
    $display("done byte lanes");
  endtask
  task t_unmapped;
    apb(1'b1, REG_ADDR, 32'h0000_0801, 4'hf);
    apb(1'b1, REG_ADDR + 12'h004, 32'hffff_ffff, 4'hf);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    chk(prst, 32'h0000_0801);
    $display("done unmapped");
  endtask
  task t_midreset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(prst, 32'h0);
    $display("done mid reset");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_all();
    t_lanes();
    t_unmapped();
    t_midreset();
    test_done();
  end
endmodule
`default_nettype wire
